//--- core/lpc_pkg.sv
package lpc_pkg;

   // Register byte offsets
   localparam logic [11:0] LPC_OFF_START  = 12'h000;
   localparam logic [11:0] LPC_OFF_STOP   = 12'h004;
   localparam logic [11:0] LPC_OFF_SAMPLE = 12'h008;
   localparam logic [11:0] LPC_OFF_READY  = 12'h100;
   localparam logic [11:0] LPC_OFF_FALL   = 12'h104;
   localparam logic [11:0] LPC_OFF_RISE   = 12'h108;
   localparam logic [11:0] LPC_OFF_CROSS  = 12'h10c;
   localparam logic [11:0] LPC_OFF_LINKS  = 12'h200;
   localparam logic [11:0] LPC_OFF_IRQSET = 12'h304;
   localparam logic [11:0] LPC_OFF_IRQCLR = 12'h308;
   localparam logic [11:0] LPC_OFF_RESULT = 12'h400;
   localparam logic [11:0] LPC_OFF_ON     = 12'h500;
   localparam logic [11:0] LPC_OFF_INSEL  = 12'h504;
   localparam logic [11:0] LPC_OFF_THRSEL = 12'h508;
   localparam logic [11:0] LPC_OFF_EXTSEL = 12'h50c;
   localparam logic [11:0] LPC_OFF_WAKE   = 12'h520;
   localparam logic [11:0] LPC_OFF_HYSTERESIS_ON   = 12'h538;

   // Event index, shared by flags and interrupt enables
   localparam int LPC_EV_READY = 0;
   localparam int LPC_EV_FALL  = 1;
   localparam int LPC_EV_RISE  = 2;
   localparam int LPC_EV_CROSS = 3;

   // Link bit positions
   localparam int LPC_LNK_RDY_SMP  = 0;
   localparam int LPC_LNK_RDY_STP  = 1;
   localparam int LPC_LNK_FALL_STP = 2;
   localparam int LPC_LNK_RISE_STP = 3;
   localparam int LPC_LNK_CROS_STP = 4;

   // Wake detect source codes
   localparam logic [1:0] LPC_WAKE_BOTH = 2'h0;
   localparam logic [1:0] LPC_WAKE_RISE = 2'h1;
   localparam logic [1:0] LPC_WAKE_FALL = 2'h2;

   // Reset values
   localparam logic [3:0] LPC_THRSEL_RST = 4'h4;
   localparam logic [2:0] LPC_INSEL_RST  = 3'h0;

   // Startup timing
   localparam int LPC_CLK_PERIOD_NS  = 10;
   localparam int LPC_STARTUP_NS     = 140000;
   localparam int LPC_STARTUP_CYCLES = (LPC_STARTUP_NS + LPC_CLK_PERIOD_NS - 1) / LPC_CLK_PERIOD_NS;

   typedef enum logic [2:0] {
      LPC_ST_IDLE = 3'b001,
      LPC_ST_WARM = 3'b010,
      LPC_ST_RUN  = 3'b100
   } lpc_state_t;

   // Settings driven to the analog core
   typedef struct packed {
      logic       power;
      logic       claim;
      logic [2:0] input_sel;
      logic [3:0] thr_sel;
      logic       ext_sel;
      logic       hysteresis_on;
   } lpc_analog_ctrl_t;

endpackage

//--- core/lpc_top.sv
// The APB slave port was chosen for this implementation.
`timescale 1ns/10ps
//////////////////////////////////////////////////////////////////////
// Overview of operation
// RL1 - Task writes of one fire once, store nothing
// RL2 - Ready flag set when output becomes valid
// RL3 - Crossings set cross plus fall or rise
// RL4 - Flags at bit zero, writing zero clears
// RL5 - Five links trigger tasks from events
// RL6 - Set register ones enable event interrupts
// RL7 - Clear register ones disable event interrupts
// RL8 - Both enable registers read enable state
// RL9 - Result holds value from last sample
// RL10 - Result one means input above threshold
// RL11 - On register enables function, resets zero
// RL12 - Input select picks one of eight
// RL13 - External select picks one of two
// RL14 - Pins claimed only while function enabled
// RL15 - Threshold select four bits, resets four
// RL16 - Ready follows start after startup time
// RL17 - Fall or rise comes with cross
// RL18 - Wake source both, rise or fall
// RL19 - Software configures first, stops before disable
// RL20 - Interrupt while enabled flag is pending
// RL21 - Crossings only between ready and stop
//////////////////////////////////////////////////////////////////////
module lpc_top
   import lpc_pkg::*;
#(
   parameter int STARTUP_CYC = LPC_STARTUP_CYCLES
) (
   // Clock, reset, enable
   input  wire logic             ref_clk,
   input  wire logic             rst,
   input  wire logic             ce,
   // APB slave
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [11:0]      paddr,
   input  wire logic [31:0]      pwdata,
   output logic                  pready,
   output logic [31:0]           prdata,
   output logic                  pslverr,
   // Analog core
   input  wire logic             cmp_above,
   output lpc_analog_ctrl_t      ana_ctrl,
   // System
   output logic                  wake_detect,
   output logic                  irq
);

   localparam int CW = $clog2(STARTUP_CYC + 1);
   localparam logic [CW-1:0] CNT_LOAD = CW'(STARTUP_CYC - 1);

   lpc_state_t       st_r;
   logic [CW-1:0]    cnt_r;
   logic             sync1_r;
   logic             sync2_r;
   logic             prev_r;
   logic [3:0]       flag_r;
   logic [3:0]       inten_r;
   logic [4:0]       links_r;
   logic             result_r;
   logic [1:0]       wake_sel_r;
   logic             wr_en;
   logic             setup;
   logic             start_tsk;
   logic             stop_tsk;
   logic             sample_tsk;
   logic [3:0]       ev;
   logic [31:0]      rd_nxt;
   logic             err_nxt;

   //////////////////////////////////////////////////////////////////
   // Bus decode: no wait state; read data comes from a flop loaded in the setup cycle
   assign setup = psel & ~penable;
   assign wr_en = psel & penable & pready & pwrite;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pready <= 1'b0;
      end else if (ce) begin
         pready <= setup & ~pready;
      end
   end

   // Register read mux and error for unmapped offsets
   always_comb begin
      rd_nxt  = 32'h0000_0000;
      err_nxt = 1'b0;
      unique case (paddr)
         LPC_OFF_START, LPC_OFF_STOP, LPC_OFF_SAMPLE: rd_nxt = 32'h0000_0000; // RL1
         LPC_OFF_READY:  rd_nxt = {31'h0, flag_r[LPC_EV_READY]}; // RL4
         LPC_OFF_FALL:   rd_nxt = {31'h0, flag_r[LPC_EV_FALL]};
         LPC_OFF_RISE:   rd_nxt = {31'h0, flag_r[LPC_EV_RISE]};
         LPC_OFF_CROSS:  rd_nxt = {31'h0, flag_r[LPC_EV_CROSS]};
         LPC_OFF_LINKS:  rd_nxt = {27'h0, links_r};
         LPC_OFF_IRQSET, LPC_OFF_IRQCLR: rd_nxt = {28'h0, inten_r}; // RL8
         LPC_OFF_RESULT: rd_nxt = {31'h0, result_r};
         LPC_OFF_ON:     rd_nxt = {31'h0, ana_ctrl.claim};
         LPC_OFF_INSEL:  rd_nxt = {29'h0, ana_ctrl.input_sel};
         LPC_OFF_THRSEL: rd_nxt = {28'h0, ana_ctrl.thr_sel};
         LPC_OFF_EXTSEL: rd_nxt = {31'h0, ana_ctrl.ext_sel};
         LPC_OFF_WAKE:   rd_nxt = {30'h0, wake_sel_r};
         LPC_OFF_HYSTERESIS_ON:   rd_nxt = {31'h0, ana_ctrl.hysteresis_on};
         default:        err_nxt = 1'b1;
      endcase
   end

   // Read data and error latched in the setup cycle
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (ce && setup) begin
         prdata  <= pwrite ? 32'h0000_0000 : rd_nxt;
         pslverr <= err_nxt;
      end
   end

   //////////////////////////////////////////////////////////////////
   // Tasks from software and from the event links
   assign start_tsk  = wr_en && paddr == LPC_OFF_START && pwdata[0]; // RL1
   assign stop_tsk   = (wr_en && paddr == LPC_OFF_STOP && pwdata[0])
                     | (ev[LPC_EV_READY] & links_r[LPC_LNK_RDY_STP]) // RL5
                     | (ev[LPC_EV_FALL]  & links_r[LPC_LNK_FALL_STP])
                     | (ev[LPC_EV_RISE]  & links_r[LPC_LNK_RISE_STP])
                     | (ev[LPC_EV_CROSS] & links_r[LPC_LNK_CROS_STP]);
   assign sample_tsk = (wr_en && paddr == LPC_OFF_SAMPLE && pwdata[0])
                     | (ev[LPC_EV_READY] & links_r[LPC_LNK_RDY_SMP]); // RL5

   //////////////////////////////////////////////////////////////////
   // Comparator output crosses in from the analog domain
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
         prev_r  <= 1'b0;
      end else if (ce) begin
         sync1_r <= cmp_above;
         sync2_r <= sync1_r;
         prev_r  <= sync2_r;
      end
   end

   // Events; edges before ready are ignored since the output is not valid yet
   assign ev[LPC_EV_READY] = (st_r == LPC_ST_WARM) && cnt_r == '0; // RL16
   assign ev[LPC_EV_RISE]  = (st_r == LPC_ST_RUN) & sync2_r & ~prev_r; // RL21
   assign ev[LPC_EV_FALL]  = (st_r == LPC_ST_RUN) & ~sync2_r & prev_r; // RL21
   assign ev[LPC_EV_CROSS] = ev[LPC_EV_RISE] | ev[LPC_EV_FALL]; // RL3 RL17

   //////////////////////////////////////////////////////////////////
   // Sequencer; stop wins over start, disable forces idle
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st_r  <= LPC_ST_IDLE;
         cnt_r <= '0;
      end else if (ce) begin
         if (stop_tsk || !ana_ctrl.claim) begin
            st_r <= LPC_ST_IDLE;
         end else if (start_tsk) begin
            st_r  <= LPC_ST_WARM; // RL16
            cnt_r <= CNT_LOAD;
         end else if (ev[LPC_EV_READY]) begin
            st_r <= LPC_ST_RUN;
         end else if (st_r == LPC_ST_WARM) begin
            cnt_r <= cnt_r - CW'(1);
         end
      end
   end

   //////////////////////////////////////////////////////////////////
   // Event flags: hardware set beats a software write in the same cycle
   for (genvar i = 0; i < 4; i++) begin : g_flag
      localparam logic [11:0] OFF = LPC_OFF_READY + 12'(4 * i);
      always_ff @(posedge ref_clk or posedge rst) begin
         if (rst) begin
            flag_r[i] <= 1'b0;
         end else if (ce) begin
            if (ev[i]) begin
               flag_r[i] <= 1'b1; // RL2 RL3
            end else if (wr_en && paddr == OFF) begin
               flag_r[i] <= pwdata[0]; // RL4
            end
         end
      end

      // A write with no event in the same cycle must store bit 0 as written
      AST_FLAG_WRITE: assert property (@(posedge ref_clk) disable iff (rst) // RL4
         ce && !ev[i] && wr_en && paddr == OFF |=> flag_r[i] == $past(pwdata[0]))
         else $error("event flag write not stored");
   end

   // Interrupt enables, set and clear by ones
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         inten_r <= 4'h0;
      end else if (ce && wr_en) begin
         if (paddr == LPC_OFF_IRQSET) begin
            inten_r <= inten_r | pwdata[3:0]; // RL6
         end else if (paddr == LPC_OFF_IRQCLR) begin
            inten_r <= inten_r & ~pwdata[3:0]; // RL7
         end
      end
   end

   // Interrupt line, one cycle behind the flags
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         irq <= 1'b0;
      end else if (ce) begin
         irq <= |(flag_r & inten_r); // RL20
      end
   end

   // Sampled result holds until the next sample
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         result_r <= 1'b0;
      end else if (ce && sample_tsk) begin
         result_r <= sync2_r; // RL9 RL10
      end
   end

   //////////////////////////////////////////////////////////////////
   // Configuration; software is expected to set these before enabling
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         links_r            <= 5'h00;
         wake_sel_r         <= LPC_WAKE_BOTH;
         ana_ctrl.claim     <= 1'b0;
         ana_ctrl.input_sel <= LPC_INSEL_RST;
         ana_ctrl.thr_sel   <= LPC_THRSEL_RST; // RL15
         ana_ctrl.ext_sel   <= 1'b0;
         ana_ctrl.hysteresis_on      <= 1'b0;
      end else if (ce && wr_en) begin
         unique case (paddr)
            LPC_OFF_LINKS:  links_r            <= pwdata[4:0]; // RL5
            LPC_OFF_ON:     ana_ctrl.claim     <= pwdata[0]; // RL11 RL14
            LPC_OFF_INSEL:  ana_ctrl.input_sel <= pwdata[2:0]; // RL12
            LPC_OFF_THRSEL: ana_ctrl.thr_sel   <= pwdata[3:0]; // RL15
            LPC_OFF_EXTSEL: ana_ctrl.ext_sel   <= pwdata[0]; // RL13
            LPC_OFF_WAKE:   wake_sel_r         <= pwdata[1:0]; // RL18
            LPC_OFF_HYSTERESIS_ON:   ana_ctrl.hysteresis_on      <= pwdata[0];
            default: ;
         endcase
      end
   end

   // Core is powered from start until stop
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ana_ctrl.power <= 1'b0;
      end else if (ce) begin
         ana_ctrl.power <= ana_ctrl.claim && !stop_tsk && (start_tsk || st_r != LPC_ST_IDLE);
      end
   end

   // Wake indication pulse; code 3 selects no source
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         wake_detect <= 1'b0;
      end else if (ce) begin
         unique case (wake_sel_r)
            LPC_WAKE_BOTH: wake_detect <= ev[LPC_EV_CROSS]; // RL18
            LPC_WAKE_RISE: wake_detect <= ev[LPC_EV_RISE];
            LPC_WAKE_FALL: wake_detect <= ev[LPC_EV_FALL];
            default:       wake_detect <= 1'b0;
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////
   // Checks; helper counts cycles spent warming up
   logic [CW:0] warm_h;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         warm_h <= '0;
      end else if (ce) begin
         warm_h <= (st_r == LPC_ST_WARM && !start_tsk) ? warm_h + (CW+1)'(1) : '0;
      end
   end

   AST_START_WARMS: assert property (@(posedge ref_clk) disable iff (rst) // RL1
      ce && start_tsk && !stop_tsk && ana_ctrl.claim |=> st_r == LPC_ST_WARM)
      else $error("start task did not begin warm-up");

   AST_READY_TIME: assert property (@(posedge ref_clk) disable iff (rst) // RL16
      ev[LPC_EV_READY] |-> warm_h == (CW+1)'(STARTUP_CYC - 1))
      else $error("ready raised at wrong startup time");

   AST_READY_FLAG: assert property (@(posedge ref_clk) disable iff (rst) // RL2
      ce && ev[LPC_EV_READY] |=> flag_r[LPC_EV_READY])
      else $error("ready flag not set");

   AST_CROSS_PAIR: assert property (@(posedge ref_clk) disable iff (rst) // RL17
      ce && (ev[LPC_EV_RISE] || ev[LPC_EV_FALL]) |=> flag_r[LPC_EV_CROSS])
      else $error("cross flag missing with edge");

   AST_NO_EDGE_IDLE: assert property (@(posedge ref_clk) disable iff (rst) // RL21
      st_r != LPC_ST_RUN |-> ev[3:1] == 3'h0)
      else $error("crossing outside run state");

   // Watches the flag itself, so a crossing leaking past the state gate is caught
   AST_NO_FLAG_IDLE: assert property (@(posedge ref_clk) disable iff (rst) // RL21
      ce && st_r != LPC_ST_RUN && !flag_r[LPC_EV_CROSS] && !(wr_en && paddr == LPC_OFF_CROSS)
      |=> !flag_r[LPC_EV_CROSS])
      else $error("cross flag set outside run state");

   AST_PINS_RELEASE: assert property (@(posedge ref_clk) disable iff (rst) // RL14
      ce && !ana_ctrl.claim |=> !ana_ctrl.power)
      else $error("core powered while function disabled");

   AST_IRQ_SET: assert property (@(posedge ref_clk) disable iff (rst) // RL6
      ce && wr_en && paddr == LPC_OFF_IRQSET |=> inten_r == ($past(inten_r) | $past(pwdata[3:0])))
      else $error("interrupt set wrong");

   AST_IRQ_CLR: assert property (@(posedge ref_clk) disable iff (rst) // RL7
      ce && wr_en && paddr == LPC_OFF_IRQCLR |=> inten_r == ($past(inten_r) & ~$past(pwdata[3:0])))
      else $error("interrupt clear wrong");

   AST_RESULT_HOLD: assert property (@(posedge ref_clk) disable iff (rst) // RL9
      !(ce && sample_tsk) |=> $stable(result_r))
      else $error("result changed without sample");

   AST_RESULT_VAL: assert property (@(posedge ref_clk) disable iff (rst) // RL10
      ce && sample_tsk |=> result_r == $past(sync2_r))
      else $error("result not sampled value");

   AST_LINK_STOP: assert property (@(posedge ref_clk) disable iff (rst) // RL5
      ce && ev[LPC_EV_CROSS] && links_r[LPC_LNK_CROS_STP] |=> st_r == LPC_ST_IDLE ##1 !ev[LPC_EV_CROSS])
      else $error("cross link did not stop");

   AST_IRQ_LINE: assert property (@(posedge ref_clk) disable iff (rst) // RL20
      ce && (flag_r & inten_r) == 4'h0 ##1 ce && (flag_r & inten_r) == 4'h0 |=> !irq)
      else $error("interrupt without enabled flag");

   COV_READY: cover property (@(posedge ref_clk) disable iff (rst) ev[LPC_EV_READY]);
   COV_RISE: cover property (@(posedge ref_clk) disable iff (rst) ev[LPC_EV_RISE]);
   COV_FALL_IRQ: cover property (@(posedge ref_clk) disable iff (rst) ev[LPC_EV_FALL] ##2 irq);
   COV_SAMPLE: cover property (@(posedge ref_clk) disable iff (rst) sample_tsk && sync2_r);
   COV_LINK_STOP: cover property (@(posedge ref_clk) disable iff (rst) ev[LPC_EV_CROSS] && links_r[LPC_LNK_CROS_STP]);

endmodule // lpc_top

//--- tb/lpc_ana_model.sv
`timescale 1ns/10ps
module lpc_ana_model
   import lpc_pkg::*;
(
   // Clock
   input  wire logic             ref_clk,
   // Core settings and levels commanded by the bench, one per analog input
   input  wire lpc_analog_ctrl_t ana_ctrl,
   input  wire logic [7:0]       in_level,
   // Comparator output
   output logic                  cmp_above
);
   logic noise_r = 1'b0;

   // Unpowered core has no valid output, so it toggles to keep a stale level from passing
   always @(posedge ref_clk) begin
      noise_r <= ~noise_r;
   end

   // Threshold and hysteresis are not modelled: the bench level already means above or below
   assign cmp_above = ana_ctrl.power ? in_level[ana_ctrl.input_sel] : noise_r;
endmodule // lpc_ana_model

//--- tb/tb_top.sv
`timescale 1ns/10ps
module tb_top
   import lpc_pkg::*;
();
   localparam int STUP = 8;
   logic             ref_clk, rst, psel, penable, pwrite, pready, pslverr, slv, cmp_above, wake_detect, irq;
   logic [11:0]      paddr;
   logic [31:0]      pwdata, prdata, rd;
   logic [7:0]       in_level;
   lpc_analog_ctrl_t ana_ctrl;
   int               n_errors = 0, check_count = 0, cycles = 0, wake_cnt = 0;
   logic [11:0]      offs [6] = '{LPC_OFF_ON, LPC_OFF_THRSEL, LPC_OFF_INSEL, LPC_OFF_RESULT, LPC_OFF_IRQSET, LPC_OFF_START};
   logic [31:0]      exps [6] = '{32'h0, 32'h4, 32'h0, 32'h0, 32'h0, 32'h0};

   // Clock enable held high: freezing is outside these tests
   lpc_top #(.STARTUP_CYC(STUP)) i_dut (.ref_clk(ref_clk), .rst(rst), .ce(1'b1), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .cmp_above(cmp_above), .ana_ctrl(ana_ctrl), .wake_detect(wake_detect), .irq(irq));
   lpc_ana_model i_ana (.ref_clk(ref_clk), .ana_ctrl(ana_ctrl), .in_level(in_level), .cmp_above(cmp_above));

   ////////////////////////////////////////////////////////////////////////////////
   // Clock
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // Cycle ceiling and wake pulse count
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (wake_detect === 1'b1) begin
         wake_cnt <= wake_cnt + 1;
      end
      if (cycles == 20000) begin
         n_errors++;
         $display("CHECK FAILED at %0t: run too long", $time);
         report_and_stop();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      $display("checks %0d, mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask

   // One APB transfer; request held until pready is seen high at an edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         n_errors++;
         $display("CHECK FAILED at %0t: no bus answer", $time);
      end
      rd = prdata;
      slv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rdchk(input logic [11:0] a, input logic [31:0] e, input string m);
      apb(1'b0, a, 32'h0);
      chk(rd, e, m);
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge ref_clk);
   endtask

   // Change the level of input 5, then allow sync, edge detect and flag update
   task automatic level(input logic v);
      in_level[5] <= v;
      idle(6);
   endtask

   // Poll the ready flag under a bound, then clear it
   task automatic wait_ready();
      int n;
      n = 0;
      do begin
         apb(1'b0, LPC_OFF_READY, 32'h0);
         n++;
      end while (rd[0] !== 1'b1 && n < 30);
      chk(rd, 32'h1, "ready flag not set");
      wr(LPC_OFF_READY, 32'h0);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      int k;
      int base;
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      in_level = 8'h00;
      idle(4);
      rst <= 1'b0;
      for (k = 0; k < 6; k++) begin
         rdchk(offs[k], exps[k], "reset value");
      end
      // Unmapped offset is refused with an error
      apb(1'b0, 12'h7fc, 32'h0);
      chk(32'(slv), 32'h1, "unmapped offset accepted");
      $display("test reset done");
      // Settings go in before the function is switched on
      wr(LPC_OFF_INSEL, 32'h5);
      wr(LPC_OFF_THRSEL, 32'h7);
      wr(LPC_OFF_EXTSEL, 32'h1);
      wr(LPC_OFF_HYSTERESIS_ON, 32'h1);
      idle(1);
      chk(32'(ana_ctrl.input_sel), 32'h5, "input select");
      chk(32'(ana_ctrl.thr_sel), 32'h7, "threshold select");
      chk(32'(ana_ctrl.ext_sel), 32'h1, "external select");
      chk(32'(ana_ctrl.claim), 32'h0, "pins claimed while off");
      chk(32'(ana_ctrl.hysteresis_on), 32'h1, "hysteresis");
      rdchk(LPC_OFF_INSEL, 32'h5, "input select readback");
      rdchk(LPC_OFF_EXTSEL, 32'h1, "external select readback");
      rdchk(LPC_OFF_THRSEL, 32'h7, "threshold readback");
      wr(LPC_OFF_ON, 32'h1);
      idle(1);
      chk(32'(ana_ctrl.claim), 32'h1, "pins not claimed");
      wr(LPC_OFF_START, 32'h1);
      rdchk(LPC_OFF_READY, 32'h0, "ready too early");
      wait_ready();
      chk(32'(ana_ctrl.power), 32'h1, "core not running");
      $display("test start done");
      // Crossing flags in both directions
      level(1'b1);
      rdchk(LPC_OFF_RISE, 32'h1, "rise flag");
      rdchk(LPC_OFF_CROSS, 32'h1, "cross with rise");
      rdchk(LPC_OFF_FALL, 32'h0, "fall flag on rise");
      wr(LPC_OFF_RISE, 32'h0);
      wr(LPC_OFF_CROSS, 32'h0);
      rdchk(LPC_OFF_RISE, 32'h0, "flag not cleared");
      level(1'b0);
      rdchk(LPC_OFF_FALL, 32'h1, "fall flag");
      rdchk(LPC_OFF_CROSS, 32'h1, "cross with fall");
      // Interrupt enable set, clear and output
      wr(LPC_OFF_IRQSET, 32'h8);
      wr(LPC_OFF_IRQSET, 32'h0);
      rdchk(LPC_OFF_IRQSET, 32'h8, "set register state");
      rdchk(LPC_OFF_IRQCLR, 32'h8, "clear register state");
      idle(2);
      chk(32'(irq), 32'h1, "irq missing");
      wr(LPC_OFF_IRQCLR, 32'h8);
      idle(2);
      chk(32'(irq), 32'h0, "irq not masked");
      rdchk(LPC_OFF_IRQSET, 32'h0, "enable not cleared");
      wr(LPC_OFF_FALL, 32'h0);
      wr(LPC_OFF_CROSS, 32'h0);
      wr(LPC_OFF_IRQSET, 32'h5);
      rdchk(LPC_OFF_IRQCLR, 32'h5, "set bits ready and rise");
      wr(LPC_OFF_IRQCLR, 32'h1);
      rdchk(LPC_OFF_IRQSET, 32'h4, "clear bit ready");
      wr(LPC_OFF_IRQCLR, 32'h4);
      $display("test events done");
      // Wake source codes: both, rise only, fall only
      for (k = 0; k < 3; k++) begin
         wr(LPC_OFF_WAKE, 32'(k));
         rdchk(LPC_OFF_WAKE, 32'(k), "wake config readback");
         base = wake_cnt;
         level(1'b1);
         chk(32'(wake_cnt - base), (k == 2) ? 32'h0 : 32'h1, "wake on rise");
         level(1'b0);
         chk(32'(wake_cnt - base), (k == 0) ? 32'h2 : 32'h1, "wake pulse count");
      end
      // Sample captures and holds the comparator output
      level(1'b1);
      wr(LPC_OFF_SAMPLE, 32'h1);
      rdchk(LPC_OFF_RESULT, 32'h1, "result above");
      level(1'b0);
      wr(LPC_OFF_SAMPLE, 32'h0);
      rdchk(LPC_OFF_RESULT, 32'h1, "result not held");
      wr(LPC_OFF_SAMPLE, 32'h1);
      rdchk(LPC_OFF_RESULT, 32'h0, "result below");
      $display("test sample done");
      // Event to stop links; level alternates so each link sees its own edge
      level(1'b1);
      for (k = 1; k < 5; k++) begin
         wr(LPC_OFF_LINKS, 32'h1 << k);
         wr(LPC_OFF_START, 32'h1);
         wait_ready();
         if (k > 1) begin
            level(~in_level[5]);
         end
         idle(2);
         chk(32'(ana_ctrl.power), 32'h0, "link did not stop");
      end
      // Ready to sample link, then a software stop
      level(~in_level[5]);
      wr(LPC_OFF_LINKS, 32'h1);
      wr(LPC_OFF_START, 32'h1);
      wait_ready();
      rdchk(LPC_OFF_RESULT, 32'h1, "ready link sample");
      wr(LPC_OFF_STOP, 32'h1);
      idle(1);
      chk(32'(ana_ctrl.power), 32'h0, "stop task ignored");
      // Stopped core ignores crossings, then is switched off
      wr(LPC_OFF_LINKS, 32'h0);
      wr(LPC_OFF_CROSS, 32'h0);
      level(~in_level[5]);
      rdchk(LPC_OFF_CROSS, 32'h0, "crossing while stopped");
      wr(LPC_OFF_ON, 32'h0);
      idle(1);
      chk(32'(ana_ctrl.claim), 32'h0, "pins kept after disable");
      $display("test links done");
      report_and_stop();
   end
endmodule // tb_top
